// ===== bandwidth_profile_policer.sv
// Functional notes
// RULE1: Green average rate bounded by committed rate plus inherited unused committed bandwidth.
// RULE2: Committed rate cap limits Green rate whatever bandwidth is inherited.
// RULE3: Committed burst size bounds short-term Green excess over long-term committed bandwidth.
// RULE4: Yellow rate bounded by excess rate plus inherited excess and coupled committed.
// RULE5: Excess rate cap limits Yellow rate whatever bandwidth is offered.
// RULE6: Excess burst size bounds short-term Yellow excess over long-term excess bandwidth.
// RULE7: Coupling flag sends unused committed to own excess or next lower rank.
// RULE8: Colour-aware mode never declares an input-Yellow frame Green.
// RULE9: Each flow has envelope id and rank steering bandwidth sharing.
// RULE10: Signed per-flow length offset adjusts charged bytes per frame.
// RULE11: For ingress, software supplies all ten flow parameters.
// RULE12: For egress, only committed rate, cap and envelope-rank are agreed.
// RULE13: Nonzero rate cap needs burst size at least the maximum frame size.
// RULE14: With envelope coupling set, every flow in it has coupling flag zero.
// RULE15: Rank lies between one and the number of flows in the envelope.
// RULE16: No two flows in one envelope share a rank.
// RULE17: Unused committed equals committed limit minus actual Green usage.
// RULE18: Unused excess equals excess limit minus actual Yellow usage.
// RULE19: Every metered frame gets exactly one colour: Green, Yellow or Red.
// RULE20: Committed bucket holds at most committed burst, excess at most excess burst.
// RULE21: Green frame debits length minus offset from committed bucket.
// RULE22: Yellow frame debits length minus offset from excess bucket.
// RULE23: Buckets refill each tick by rate over eight times tick, saturating.
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`include "policer_defines.svh"

module bandwidth_profile_policer
  import policer_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input frame_req_t req,
  input wire logic req_valid,
  output logic req_ready,
  output frame_res_t res,
  output logic res_valid
);

  localparam logic [31:0] RATE_DIV =
    32'(`BITS_PER_BYTE_NS / (64'(TICK_CYCLES) * 64'(`CLK_PERIOD_NS)));

  pol_state_t q, d;
  logic [`NFLOW-1:0] act;
  logic [`NFLOW-1:0][31:0] nc, ne, cco, eco;
  logic req_fire, walking;
  logic [17:0] cost_s;
  logic [31:0] cost, cur_cb, cur_eb, res_cb, res_eb;
  colour_t col;
  reg_sel_t wsel, rsel;
  logic [31:0] wmrg;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic reg_sel_t decode(logic [11:0] a);
    reg_sel_t r;
    r.glob = (a == `OFF_ENV_COUPLING);
    r.flow = a[7:6];
    r.off = a[5:0];
    r.ro = (a[5:0] == `OFF_COMMIT_LEVEL) || (a[5:0] == `OFF_EXCESS_LEVEL);
    r.hit = r.glob || (a[11:8] == 4'h0 && a[5:0] <= `OFF_EXCESS_LEVEL && a[1:0] == 2'h0);
    return r;
  endfunction : decode

  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n, logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = n[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] ctrl_pack(flow_cfg_t c);
    logic [31:0] r;
    r = `RST_WORD;
    r[`CTRL_CF_BIT] = c.coupling_flag;
    r[`CTRL_CM_BIT] = c.colour_mode;
    r[`CTRL_ENV_LSB +: 2] = c.envelope_rank_pair.env_id;
    r[`CTRL_RANK_LSB +: 3] = c.envelope_rank_pair.rank;
    return r;
  endfunction : ctrl_pack

  function automatic pol_state_t rst_state();
    pol_state_t r;
    r = '0;
    r.st = ST_IDLE;
    for (int f = 0; f < `NFLOW; f++) begin
      r.cfg[f].envelope_rank_pair.rank = `RST_RANK_BASE + 3'(f);
    end
    return r;
  endfunction : rst_state

  // ----------------------------------------
  // Per-flow refill
  // ----------------------------------------
  generate
    for (genvar f = 0; f < `NFLOW; f++) begin : g_flow
      // RULE9 rank order
      assign act[f] = walking && (q.cfg[f].envelope_rank_pair.rank == q.rank);
      bucket_step #(.RATE_DIV(RATE_DIV)) u_step (
        .cfg(q.cfg[f]),
        .active(act[f]),
        .c_bkt(q.cbkt[f]),
        .e_bkt(q.ebkt[f]),
        .c_carry_in(q.carry_c[q.cfg[f].envelope_rank_pair.env_id]),
        .e_carry_in(q.carry_e[q.cfg[f].envelope_rank_pair.env_id]),
        .c_bkt_next(nc[f]),
        .e_bkt_next(ne[f]),
        .c_carry_out(cco[f]),
        .e_carry_out(eco[f])
      );
      // RULE2 committed cap
      commit_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (act[f] && q.cbkt[f] <= q.cfg[f].commit_burst_bytes) |->
        (nc[f] - q.cbkt[f] <= q.cfg[f].commit_rate_cap / RATE_DIV))
        else $error("committed refill above cap");
      // RULE5 excess cap
      excess_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (act[f] && q.ebkt[f] <= q.cfg[f].excess_burst_bytes) |->
        (ne[f] - q.ebkt[f] <= q.cfg[f].excess_rate_cap / RATE_DIV))
        else $error("excess refill above cap");
      bucket_cap_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE20
        act[f] |=> (q.cbkt[f] <= $past(q.cfg[f].commit_burst_bytes)) &&
        (q.ebkt[f] <= $past(q.cfg[f].excess_burst_bytes)))
        else $error("bucket above burst after refill");
    end
  endgenerate

  // ----------------------------------------
  // Frame decision
  // ----------------------------------------
  assign walking = (q.st == ST_WALK);
  assign req_ready = (q.st == ST_IDLE);
  assign req_fire = req_valid && req_ready;
  assign cur_cb = q.cbkt[req.flow];
  assign cur_eb = q.ebkt[req.flow];
  assign res_cb = q.cbkt[q.res.flow];
  assign res_eb = q.ebkt[q.res.flow];

  always_comb begin
    // RULE10 length offset
    cost_s = {2'h0, req.len} - {{2{q.cfg[req.flow].len_offset[15]}}, q.cfg[req.flow].len_offset};
    cost = cost_s[17] ? 32'h0 : {14'h0, cost_s};
    // RULE19 RULE8 RULE3 RULE6 one colour
    if (cur_cb >= cost && !(q.cfg[req.flow].colour_mode && req.in_yellow)) begin
      col = COL_GREEN;
    end else if (cur_eb >= cost) begin
      col = COL_YELLOW;
    end else begin
      col = COL_RED;
    end
  end

  assign wsel = decode(q.awaddr);
  assign rsel = decode(araddr);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;
    wmrg = `RST_WORD;
    d.res_valid = 1'b0;
    if (awvalid && awready) begin
      d.aw_got = 1'b1;
      d.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      d.w_got = 1'b1;
      d.wdata = wdata;
      d.wstrb = wstrb;
    end
    if (q.aw_got && q.w_got) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = wsel.hit ? `RESP_OKAY : `RESP_SLVERR;
      if (wsel.glob) begin
        wmrg = merge({28'h0, q.env_cf}, q.wdata, q.wstrb);
        d.env_cf = wmrg[3:0];
      end else if (wsel.hit && !wsel.ro) begin
        case (wsel.off)
          `OFF_COMMIT_RATE: d.cfg[wsel.flow].commit_rate =
            merge(q.cfg[wsel.flow].commit_rate, q.wdata, q.wstrb);
          `OFF_COMMIT_CAP: d.cfg[wsel.flow].commit_rate_cap =
            merge(q.cfg[wsel.flow].commit_rate_cap, q.wdata, q.wstrb);
          `OFF_COMMIT_BURST: d.cfg[wsel.flow].commit_burst_bytes =
            merge(q.cfg[wsel.flow].commit_burst_bytes, q.wdata, q.wstrb);
          `OFF_EXCESS_RATE: d.cfg[wsel.flow].excess_rate =
            merge(q.cfg[wsel.flow].excess_rate, q.wdata, q.wstrb);
          `OFF_EXCESS_CAP: d.cfg[wsel.flow].excess_rate_cap =
            merge(q.cfg[wsel.flow].excess_rate_cap, q.wdata, q.wstrb);
          `OFF_EXCESS_BURST: d.cfg[wsel.flow].excess_burst_bytes =
            merge(q.cfg[wsel.flow].excess_burst_bytes, q.wdata, q.wstrb);
          `OFF_FLOW_CTRL: begin
            wmrg = merge(ctrl_pack(q.cfg[wsel.flow]), q.wdata, q.wstrb);
            d.cfg[wsel.flow].coupling_flag = wmrg[`CTRL_CF_BIT];
            d.cfg[wsel.flow].colour_mode = wmrg[`CTRL_CM_BIT];
            d.cfg[wsel.flow].envelope_rank_pair.env_id = wmrg[`CTRL_ENV_LSB +: 2];
            d.cfg[wsel.flow].envelope_rank_pair.rank = wmrg[`CTRL_RANK_LSB +: 3];
          end
          `OFF_LEN_OFFSET: begin
            wmrg = merge({16'h0, q.cfg[wsel.flow].len_offset}, q.wdata, q.wstrb);
            d.cfg[wsel.flow].len_offset = $signed(wmrg[15:0]);
          end
          default: d.bresp = `RESP_OKAY;
        endcase
      end
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      d.rvalid = 1'b1;
      d.rresp = rsel.hit ? `RESP_OKAY : `RESP_SLVERR;
      d.rdata = `RST_WORD;
      if (rsel.glob) begin
        d.rdata = {28'h0, q.env_cf};
      end else if (rsel.hit) begin
        case (rsel.off)
          `OFF_COMMIT_RATE: d.rdata = q.cfg[rsel.flow].commit_rate;
          `OFF_COMMIT_CAP: d.rdata = q.cfg[rsel.flow].commit_rate_cap;
          `OFF_COMMIT_BURST: d.rdata = q.cfg[rsel.flow].commit_burst_bytes;
          `OFF_EXCESS_RATE: d.rdata = q.cfg[rsel.flow].excess_rate;
          `OFF_EXCESS_CAP: d.rdata = q.cfg[rsel.flow].excess_rate_cap;
          `OFF_EXCESS_BURST: d.rdata = q.cfg[rsel.flow].excess_burst_bytes;
          `OFF_FLOW_CTRL: d.rdata = ctrl_pack(q.cfg[rsel.flow]);
          `OFF_LEN_OFFSET: d.rdata = {{16{q.cfg[rsel.flow].len_offset[15]}},
                                      q.cfg[rsel.flow].len_offset};
          `OFF_COMMIT_LEVEL: d.rdata = q.cbkt[rsel.flow];
          `OFF_EXCESS_LEVEL: d.rdata = q.ebkt[rsel.flow];
          default: d.rdata = `RST_WORD;
        endcase
      end
    end
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (req_fire) begin
      d.res_valid = 1'b1;
      d.res.flow = req.flow;
      d.res.colour = col;
      d.res_cost = cost;
      // RULE21 green debit
      if (col == COL_GREEN) begin
        d.cbkt[req.flow] = cur_cb - cost;
      end
      // RULE22 yellow debit
      if (col == COL_YELLOW) begin
        d.ebkt[req.flow] = cur_eb - cost;
      end
    end
    case (q.st)
      ST_IDLE: begin
        d.tick = q.tick + 32'h1;
        if (q.tick >= 32'(TICK_CYCLES - 1)) begin
          d.tick = 32'h0;
          d.st = ST_WALK;
          d.rank = 3'(`NFLOW);
          for (int e = 0; e < `NENV; e++) begin
            d.carry_c[e] = 32'h0;
            d.carry_e[e] = q.env_cf[e] ? q.carry_c[e] : 32'h0;
          end
        end
      end
      ST_WALK: begin
        // RULE23 RULE9 refill by rank
        for (int f = 0; f < `NFLOW; f++) begin
          if (act[f]) begin
            d.cbkt[f] = nc[f];
            d.ebkt[f] = ne[f];
            d.carry_c[q.cfg[f].envelope_rank_pair.env_id] = cco[f];
            d.carry_e[q.cfg[f].envelope_rank_pair.env_id] = eco[f];
          end
        end
        d.rank = q.rank - 3'h1;
        if (q.rank == 3'h1) begin
          d.st = ST_IDLE;
        end
      end
      default: d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= rst_state();
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign awready = !q.aw_got && !q.bvalid;
  assign wready = !q.w_got && !q.bvalid;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = !q.rvalid;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign res = q.res;
  assign res_valid = q.res_valid;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  colour_valid_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE19
    req_fire |=> res_valid && (res.colour inside {COL_GREEN, COL_YELLOW, COL_RED}))
    else $error("metered frame without a valid colour");
  green_debit_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE21
    (req_fire && col == COL_GREEN) |=> res_cb == $past(cur_cb) - $past(cost))
    else $error("green frame did not debit committed bucket");
  yellow_debit_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE22
    (req_fire && col == COL_YELLOW) |=> res_eb == $past(cur_eb) - $past(cost))
    else $error("yellow frame did not debit excess bucket");
  colour_aware_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
    (req_fire && req.in_yellow && q.cfg[req.flow].colour_mode) |=> res.colour != COL_GREEN)
    else $error("colour-aware yellow frame declared green");
  green_tokens_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
    (req_fire && col == COL_GREEN) |-> cur_cb >= cost)
    else $error("green declared without committed tokens");
  red_empty_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE19
    (req_fire && cur_cb < cost && cur_eb < cost) |=> res.colour == COL_RED)
    else $error("frame without tokens not declared red");
  walk_length_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
    $rose(walking) |-> walking[*4] ##1 !walking)
    else $error("refill walk not four cycles");

endmodule : bandwidth_profile_policer

// ===== bucket_step.sv
`include "policer_defines.svh"

module bucket_step
  import policer_pkg::*;
#(
  parameter logic [31:0] RATE_DIV = 32'h0000_0001
) (
  input flow_cfg_t cfg,
  input wire logic active,
  input wire logic [31:0] c_bkt,
  input wire logic [31:0] e_bkt,
  input wire logic [31:0] c_carry_in,
  input wire logic [31:0] e_carry_in,
  output logic [31:0] c_bkt_next,
  output logic [31:0] e_bkt_next,
  output logic [31:0] c_carry_out,
  output logic [31:0] e_carry_out
);

  logic [31:0] c_tok, e_tok, c_cap_tok, e_cap_tok;
  logic [33:0] c_in, e_in;
  logic [31:0] c_lim, e_lim, c_room, e_room, c_add, e_add, c_unused, e_unused;

  // ----------------------------------------
  // Tokens per tick
  // ----------------------------------------
  assign c_tok = cfg.commit_rate / RATE_DIV;
  assign e_tok = cfg.excess_rate / RATE_DIV;
  assign c_cap_tok = cfg.commit_rate_cap / RATE_DIV;
  assign e_cap_tok = cfg.excess_rate_cap / RATE_DIV;

  always_comb begin
    // RULE1 RULE2 committed inflow
    c_in = {2'h0, c_tok} + {2'h0, c_carry_in};
    c_lim = (c_in > {2'h0, c_cap_tok}) ? c_cap_tok : c_in[31:0];
    // RULE20 RULE23 saturate at burst
    c_room = (cfg.commit_burst_bytes > c_bkt) ? cfg.commit_burst_bytes - c_bkt : 32'h0;
    c_add = (c_lim < c_room) ? c_lim : c_room;
    // RULE17 unused committed
    c_unused = c_lim - c_add;
    // RULE4 RULE5 RULE7 excess inflow
    e_in = {2'h0, e_tok} + {2'h0, e_carry_in} +
           (cfg.coupling_flag ? {2'h0, c_unused} : 34'h0);
    e_lim = (e_in > {2'h0, e_cap_tok}) ? e_cap_tok : e_in[31:0];
    e_room = (cfg.excess_burst_bytes > e_bkt) ? cfg.excess_burst_bytes - e_bkt : 32'h0;
    e_add = (e_lim < e_room) ? e_lim : e_room;
    // RULE18 unused excess
    e_unused = e_lim - e_add;
    c_bkt_next = c_bkt;
    e_bkt_next = e_bkt;
    c_carry_out = c_carry_in;
    e_carry_out = e_carry_in;
    if (active) begin
      c_bkt_next = (c_bkt > cfg.commit_burst_bytes) ? cfg.commit_burst_bytes : c_bkt + c_add;
      e_bkt_next = (e_bkt > cfg.excess_burst_bytes) ? cfg.excess_burst_bytes : e_bkt + e_add;
      // RULE7 coupling choice
      c_carry_out = cfg.coupling_flag ? 32'h0 : c_unused;
      e_carry_out = e_unused;
    end
  end

endmodule : bucket_step

// ===== frame_source.sv
module frame_source
  import policer_pkg::*;
(
  input wire logic aclk,
  output frame_req_t req,
  output logic req_valid,
  input wire logic req_ready
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // Frame offer
  // ----------------------------------------
  initial begin
    req = '0;
    req_valid = 1'b0;
  end

  // Holds the frame until taken or for at most 100 cycles, then scrambles the idle bus
  task automatic send(input frame_req_t f, output bit ok);
    int n;
    req <= f;
    req_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (req_ready !== 1'b1 && n < 100);
    ok = (req_ready === 1'b1);
    req <= ~f;
    req_valid <= 1'b0;
    @(posedge aclk);
  endtask : send
endmodule : frame_source

// ===== policer_defines.svh
`ifndef POLICER_DEFINES_SVH
`define POLICER_DEFINES_SVH

// ----------------------------------------
// Sizes and timing
// ----------------------------------------
`define NFLOW 4
`define NENV 4
`define CLK_PERIOD_NS 50
`define TICK_PERIOD_NS 1000000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define BITS_PER_BYTE_NS 64'd8000000000

// ----------------------------------------
// Register offsets (byte address within a flow block of 64 bytes)
// ----------------------------------------
`define OFF_COMMIT_RATE 6'h00
`define OFF_COMMIT_CAP 6'h04
`define OFF_COMMIT_BURST 6'h08
`define OFF_EXCESS_RATE 6'h0C
`define OFF_EXCESS_CAP 6'h10
`define OFF_EXCESS_BURST 6'h14
`define OFF_FLOW_CTRL 6'h18
`define OFF_LEN_OFFSET 6'h1C
`define OFF_COMMIT_LEVEL 6'h20
`define OFF_EXCESS_LEVEL 6'h24
`define OFF_ENV_COUPLING 12'h100

// ----------------------------------------
// Flow control word fields
// ----------------------------------------
`define CTRL_CF_BIT 0
`define CTRL_CM_BIT 1
`define CTRL_ENV_LSB 4
`define CTRL_RANK_LSB 8

// ----------------------------------------
// Reset values and response codes
// ----------------------------------------
`define RST_WORD 32'h0000_0000
`define RST_RANK_BASE 3'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== policer_pkg.sv
`include "policer_defines.svh"

package policer_pkg;

  typedef enum logic [1:0] {
    COL_GREEN = 2'h0,
    COL_YELLOW = 2'h1,
    COL_RED = 2'h2
  } colour_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WALK = 2'b10
  } walk_state_t;

  typedef struct packed {
    logic [1:0] env_id;
    logic [2:0] rank;
  } envelope_rank_pair_t;

  typedef struct packed {
    logic [31:0] commit_rate;
    logic [31:0] commit_rate_cap;
    logic [31:0] commit_burst_bytes;
    logic [31:0] excess_rate;
    logic [31:0] excess_rate_cap;
    logic [31:0] excess_burst_bytes;
    logic coupling_flag;
    logic colour_mode;
    envelope_rank_pair_t envelope_rank_pair;
    logic signed [15:0] len_offset;
  } flow_cfg_t;

  typedef struct packed {
    logic [1:0] flow;
    logic [15:0] len;
    logic in_yellow;
  } frame_req_t;

  typedef struct packed {
    logic [1:0] flow;
    colour_t colour;
  } frame_res_t;

  typedef struct packed {
    logic hit;
    logic glob;
    logic ro;
    logic [1:0] flow;
    logic [5:0] off;
  } reg_sel_t;

  typedef struct packed {
    flow_cfg_t [`NFLOW-1:0] cfg;
    logic [`NFLOW-1:0][31:0] cbkt;
    logic [`NFLOW-1:0][31:0] ebkt;
    logic [`NENV-1:0] env_cf;
    logic [`NENV-1:0][31:0] carry_c;
    logic [`NENV-1:0][31:0] carry_e;
    logic [31:0] tick;
    walk_state_t st;
    logic [2:0] rank;
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic res_valid;
    frame_res_t res;
    logic [31:0] res_cost;
  } pol_state_t;

endpackage : policer_pkg

// ===== tb.sv
module tb
  import policer_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [31:0] BIG = 32'h5F5E_1000;
  logic aclk = 1'b0;
  logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, req_valid, req_ready, res_valid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  frame_req_t req;
  frame_res_t res;
  int error_cnt = 0;
  int checked = 0;
  integer seed = 32'hEE45_B513;
  frame_res_t fq[$];
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [11:0] rate_regs[4] = '{12'h000, 12'h004, 12'h00C, 12'h010};

  bandwidth_profile_policer #(.TICK_CYCLES(200)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .res(res), .res_valid(res_valid)
  );

  frame_source i_src (
    .aclk(aclk), .req(req), .req_valid(req_valid), .req_ready(req_ready)
  );

  always #25 aclk = ~aclk;

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic hang();
    chk("timeout", 34'h0, 34'h1);
    stop_test();
  endtask : hang

  always @(posedge aclk) begin
    if (res_valid === 1'b1) begin
      chk("colour", fq.size() > 0 ? 34'(fq.pop_front()) : '1, 34'(res));
    end
    if (rvalid === 1'b1 && rready === 1'b1) begin
      chk("rdata", rq.size() > 0 ? rq.pop_front() : '1, {rresp, rdata});
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      chk("bresp", bq.size() > 0 ? 34'(bq.pop_front()) : '1, 34'(bresp));
    end
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    bq.push_back(er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 200);
    bready <= 1'b0;
    if (n >= 200) hang();
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    rq.push_back({er, ed});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 200);
    rready <= 1'b0;
    if (n >= 200) hang();
    @(posedge aclk);
  endtask : rd

  task automatic frm(input logic [1:0] f, input logic [15:0] l, input logic y, input colour_t c);
    bit ok;
    fq.push_back(frame_res_t'{f, c});
    i_src.send(frame_req_t'{f, l, y}, ok);
    if (!ok) hang();
  endtask : frm

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(12'h018, 32'h0000_0100, 2'h0);
    rd(12'h0D8, 32'h0000_0400, 2'h0);
    rd(12'h200, 32'h0, 2'h2);
    wr(12'h200, 32'h1, 2'h2);
    wr(12'h008, 32'h0000_03E8, 2'h0);
    wr(12'h014, 32'h0000_01F4, 2'h0);
    wr(12'h000, BIG, 2'h0);
    repeat (250) @(posedge aclk);
    rd(12'h020, 32'h0, 2'h0);
    wr(12'h004, BIG, 2'h0);
    wr(12'h00C, BIG, 2'h0);
    wr(12'h010, BIG, 2'h0);
    repeat (250) @(posedge aclk);
    rd(12'h020, 32'h0000_03E8, 2'h0);
    rd(12'h024, 32'h0000_01F4, 2'h0);
    foreach (rate_regs[i]) wr(rate_regs[i], 32'h0, 2'h0);
    wr(12'h018, 32'h0000_0102, 2'h0);
    frm(2'h0, 16'h0258, 1'b0, COL_GREEN);
    frm(2'h0, 16'h012C, 1'b1, COL_YELLOW);
    frm(2'h0, 16'h012C, 1'b0, COL_GREEN);
    frm(2'h0, 16'h012C, 1'b0, COL_RED);
    rd(12'h020, 32'h0000_0064, 2'h0);
    rd(12'h024, 32'h0000_00C8, 2'h0);
    wr(12'h020, 32'h0000_03FF, 2'h0);
    rd(12'h020, 32'h0000_0064, 2'h0);
    wr(12'h01C, 32'h0000_FFCE, 2'h0);
    rd(12'h01C, 32'hFFFF_FFCE, 2'h0);
    frm(2'h0, 16'h0032, 1'b0, COL_GREEN);
    frm(2'h0, 16'h0032, 1'b0, COL_YELLOW);
    wr(12'h01C, 32'h0000_0032, 2'h0);
    frm(2'h0, 16'h0014, 1'b1, COL_YELLOW);
    wr(12'h018, 32'h0000_0100, 2'h0);
    frm(2'h0, 16'h0014, 1'b1, COL_GREEN);
    for (int i = 0; i < 8; i++) begin
      frm(2'(32'h1 + {$random(seed)} % 32'h3), 16'(32'h1 + {$random(seed)} % 32'h5DC),
          1'($random(seed)), COL_RED);
    end
    wr(12'h018, 32'h0000_0101, 2'h0);
    wr(12'h000, BIG, 2'h0);
    wr(12'h004, BIG, 2'h0);
    wr(12'h010, BIG, 2'h0);
    repeat (250) @(posedge aclk);
    rd(12'h024, 32'h0000_01F4, 2'h0);
    rd(12'h020, 32'h0000_03E8, 2'h0);
    wr(12'h018, 32'h0000_0100, 2'h0);
    wr(12'h100, 32'h0000_0001, 2'h0);
    rd(12'h100, 32'h0000_0001, 2'h0);
    repeat (4) @(posedge aclk);
    chk("pending", 34'h0, 34'(fq.size() + rq.size() + bq.size()));
    stop_test();
  end
endmodule : tb
